// >>> sfsp_pkg.sv
package sfsp_pkg;

    // array geometry
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned SECTOR_BYTES = 4096;
    localparam int unsigned HALF_BLOCK_BYTES = 32768;
    localparam int unsigned BLOCK_BYTES = 65536;
    localparam int unsigned SECTOR_COUNT = 256;
    localparam logic [23:0] SECTOR_MASK = 24'hFFF000;
    localparam logic [23:0] HALF_MASK = 24'hFF8000;
    localparam logic [23:0] BLOCK_MASK = 24'hFF0000;

    // protected region upper limits, region always starts at zero
    localparam logic [23:0] LIM_CODE1 = 24'h0FDFFF;
    localparam logic [23:0] LIM_CODE2 = 24'h0FBFFF;
    localparam logic [23:0] LIM_CODE3 = 24'h0F7FFF;
    localparam logic [23:0] LIM_CODE4 = 24'h0EFFFF;
    localparam logic [23:0] LIM_CODE5 = 24'h0DFFFF;
    localparam logic [23:0] LIM_CODE6 = 24'h0BFFFF;

    // instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_STATUS_READ_INSTR = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE_INSTR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_PP_FAST = 8'hF2;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_CE_A = 8'hC7;
    localparam logic [7:0] OP_CE_B = 8'h60;
    localparam logic [7:0] OP_DP = 8'hB9;
    localparam logic [7:0] OP_RDP = 8'hAB;
    localparam logic [7:0] OP_DUAL = 8'h3B;

    // status field positions
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_WEL = 1;
    localparam int unsigned ST_BP_LO = 2;
    localparam int unsigned ST_LOCK = 7;

    // values after reset
    localparam logic RST_LOCK = 1'b0;
    localparam logic [2:0] RST_BP = 3'h0;

    // frame byte counts, last bit index and last pair index
    localparam logic [2:0] BYTES_ONE = 3'h1;
    localparam logic [2:0] BYTES_STATUS_WRITE_INSTR = 3'h2;
    localparam logic [2:0] BYTES_ADDR = 3'h4;
    localparam logic [2:0] BYTES_PP_MIN = 3'h5;
    localparam logic [2:0] BYTES_DUAL = 3'h5;
    localparam logic [2:0] BYTES_SAT = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] PAIR_LAST = 2'h3;

    // synchronised pin indices and reset levels
    localparam int unsigned PIN_COUNT = 5;
    localparam int unsigned PIN_SCLK = 0;
    localparam int unsigned PIN_CS_N = 1;
    localparam int unsigned PIN_SI = 2;
    localparam int unsigned PIN_WP_N = 3;
    localparam int unsigned PIN_POR = 4;
    // chip select resets low so only a real high arms the first select
    localparam logic [4:0] PIN_RST = 5'h08;

    typedef enum logic [2:0] {
        CYC_NONE = 3'b000,
        CYC_PP = 3'b001,
        CYC_SE = 3'b010,
        CYC_BE32 = 3'b011,
        CYC_BE64 = 3'b100,
        CYC_CE = 3'b101,
        CYC_STATUS_WRITE_INSTR = 3'b110
    } sfsp_cyc_e;

    typedef enum logic [1:0] {
        FR_WAIT_HIGH = 2'b00,
        FR_IDLE = 2'b01,
        FR_SHIFT = 2'b10
    } sfsp_fr_e;

    typedef struct packed {
        sfsp_cyc_e kind;
        logic [23:0] addr;
        logic [7:0] status;
    } sfsp_cyc_s;

endpackage

// >>> sfsp_pin_sync.sv
`timescale 1ns/10ps
module sfsp_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_pin,
    output logic o_level
);
    logic [2:0] stg_q;
    logic [2:0] stg_d;
    logic lvl_q;
    logic lvl_d;

    // change counts only once stages two and three agree
    always_comb begin
        stg_d = {stg_q[1:0], i_pin};
        lvl_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : lvl_q;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            stg_q <= {3{RST_VAL}};
            lvl_q <= RST_VAL;
        end else begin
            stg_q <= stg_d;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;
endmodule // sfsp_pin_sync

// >>> sfsp_status_protect.sv
`timescale 1ns/10ps
module sfsp_status_protect #(
    parameter int unsigned ADDR_W = sfsp_pkg::ADDR_W
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_lane0,
    output logic o_lane0,
    output logic o_lane0_oe,
    input wire logic i_lane1,
    output logic o_lane1,
    output logic o_lane1_oe,
    input wire logic i_wp_n,
    input wire logic i_por_hold,
    input wire logic [7:0] i_read_data,
    output logic [ADDR_W-1:0] o_read_addr,
    output logic o_cycle_start,
    output sfsp_pkg::sfsp_cyc_s o_cycle,
    input wire logic i_cycle_done,
    output logic [7:0] o_status,
    output logic o_active,
    output logic o_standby,
    output logic o_deep_pd
);
    initial begin
        if (ADDR_W != 24) begin
            $error("sfsp_status_protect: ADDR_W must be 24");
        end
    end

    logic [sfsp_pkg::PIN_COUNT-1:0] pin_raw;
    logic [sfsp_pkg::PIN_COUNT-1:0] pin_s;

    // lane 1 input stays unused: only dual output is supported
    assign pin_raw = {i_por_hold, i_wp_n, i_lane0, i_cs_n, i_sclk};

    genvar gi;
    generate
        for (gi = 0; gi < sfsp_pkg::PIN_COUNT; gi++) begin : g_sync
            sfsp_pin_sync #(
                .RST_VAL(sfsp_pkg::PIN_RST[gi])
            ) u_sync (
                .i_clk_sys(i_clk_sys),
                .i_reset(i_reset),
                .i_pin(pin_raw[gi]),
                .o_level(pin_s[gi])
            );
        end
    endgenerate

    function automatic logic prot_hit(input logic [2:0] code,
                                      input logic [23:0] a);
        logic hit;
        hit = 1'b0;
        case (code)
            3'h0: hit = 1'b0;
            3'h1: hit = (a <= sfsp_pkg::LIM_CODE1);
            3'h2: hit = (a <= sfsp_pkg::LIM_CODE2);
            3'h3: hit = (a <= sfsp_pkg::LIM_CODE3);
            3'h4: hit = (a <= sfsp_pkg::LIM_CODE4);
            3'h5: hit = (a <= sfsp_pkg::LIM_CODE5);
            3'h6: hit = (a <= sfsp_pkg::LIM_CODE6);
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    sfsp_pkg::sfsp_fr_e fr_q, fr_d;
    logic sclk_p_q, sclk_p_d;
    logic cs_p_q, cs_p_d;
    logic [2:0] bit_q, bit_d;
    logic [2:0] byte_q, byte_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] op_q, op_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d;
    logic lock_q, lock_d;
    logic [2:0] bp_q, bp_d;
    logic wel_q, wel_d;
    logic busy_q, busy_d;
    logic dpd_q, dpd_d;
    logic start_q, start_d;
    sfsp_pkg::sfsp_cyc_s cyc_q, cyc_d;
    logic so_q, so_d;
    logic so_oe_q, so_oe_d;
    logic l0_q, l0_d;
    logic l0_oe_q, l0_oe_d;
    logic [1:0] pair_q, pair_d;
    logic [23:0] raddr_q, raddr_d;

    logic rise, fall, cs_fall, cs_rise, por;
    logic [7:0] byte_in;
    logic [7:0] status;
    logic hw_locked;

    assign por = pin_s[sfsp_pkg::PIN_POR];
    assign rise = pin_s[sfsp_pkg::PIN_SCLK] & ~sclk_p_q;
    assign fall = ~pin_s[sfsp_pkg::PIN_SCLK] & sclk_p_q;
    assign cs_fall = ~pin_s[sfsp_pkg::PIN_CS_N] & cs_p_q;
    assign cs_rise = pin_s[sfsp_pkg::PIN_CS_N] & ~cs_p_q;
    assign byte_in = {shift_q[6:0], pin_s[sfsp_pkg::PIN_SI]};
    assign hw_locked = lock_q & ~pin_s[sfsp_pkg::PIN_WP_N];
    assign status = {lock_q, 2'b00, bp_q, wel_q, busy_q};

    always_comb begin
        fr_d = fr_q;
        sclk_p_d = pin_s[sfsp_pkg::PIN_SCLK];
        cs_p_d = pin_s[sfsp_pkg::PIN_CS_N];
        bit_d = bit_q;
        byte_d = byte_q;
        shift_d = shift_q;
        op_d = op_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        lock_d = lock_q;
        bp_d = bp_q;
        wel_d = wel_q;
        busy_d = busy_q;
        dpd_d = dpd_q;
        start_d = 1'b0;
        cyc_d = cyc_q;
        so_d = so_q;
        so_oe_d = so_oe_q;
        l0_d = l0_q;
        l0_oe_d = l0_oe_q;
        pair_d = pair_q;
        raddr_d = raddr_q;

        if (busy_q && i_cycle_done) begin
            busy_d = 1'b0;
            wel_d = 1'b0;
        end

        case (fr_q)
            // wait for a high chip select
            sfsp_pkg::FR_WAIT_HIGH: begin
                if (pin_s[sfsp_pkg::PIN_CS_N]) begin
                    fr_d = sfsp_pkg::FR_IDLE;
                end
            end
            sfsp_pkg::FR_IDLE: begin
                if (cs_fall) begin
                    fr_d = sfsp_pkg::FR_SHIFT;
                    bit_d = 3'h0;
                    byte_d = 3'h0;
                    pair_d = 2'h0;
                end
            end
            sfsp_pkg::FR_SHIFT: begin
                // mode 0 and 3 both idle-safe here
                if (rise) begin
                    shift_d = byte_in;
                    bit_d = bit_q + 3'h1;
                    if (bit_q == sfsp_pkg::BIT_LAST) begin
                        if (byte_q != sfsp_pkg::BYTES_SAT) begin
                            byte_d = byte_q + 3'h1;
                        end
                        case (byte_q)
                            3'h0: op_d = byte_in;
                            3'h1: begin
                                addr_d[23:16] = byte_in;
                                wdata_d = byte_in;
                            end
                            3'h2: addr_d[15:8] = byte_in;
                            3'h3: addr_d[7:0] = byte_in;
                            default: ;
                        endcase
                    end
                end
                if (fall && byte_q != 3'h0 && !dpd_q) begin
                    if (op_q == sfsp_pkg::OP_STATUS_READ_INSTR) begin
                        so_d = status[3'h7 - bit_q];
                        so_oe_d = 1'b1;
                    end
                    // two lanes, odd bits on lane one
                    if (op_q == sfsp_pkg::OP_DUAL &&
                        byte_q >= sfsp_pkg::BYTES_DUAL) begin
                        if (!so_oe_q) begin
                            raddr_d = addr_q;
                        end
                        so_d = i_read_data[3'h7 - {pair_q, 1'b0}];
                        l0_d = i_read_data[3'h6 - {pair_q, 1'b0}];
                        so_oe_d = 1'b1;
                        l0_oe_d = 1'b1;
                        pair_d = pair_q + 2'h1;
                        if (pair_q == sfsp_pkg::PAIR_LAST) begin
                            raddr_d = (so_oe_q ? raddr_q : addr_q) + 24'h1;
                        end
                    end
                end
                if (cs_rise) begin
                    fr_d = sfsp_pkg::FR_IDLE;
                    so_oe_d = 1'b0;
                    l0_oe_d = 1'b0;
                    // whole bytes only; a cut byte rejects the command
                    if (bit_q == 3'h0) begin
                        if (dpd_q) begin
                            if (op_q == sfsp_pkg::OP_RDP) begin
                                dpd_d = 1'b0;
                            end
                        end else if (!busy_q) begin
                            case (op_q)
                                sfsp_pkg::OP_WREN: begin
                                    if (byte_q == sfsp_pkg::BYTES_ONE) begin
                                        wel_d = 1'b1;
                                    end
                                end
                                sfsp_pkg::OP_WRDI: begin
                                    if (byte_q == sfsp_pkg::BYTES_ONE) begin
                                        wel_d = 1'b0;
                                    end
                                end
                                sfsp_pkg::OP_DP: begin
                                    if (byte_q == sfsp_pkg::BYTES_ONE) begin
                                        dpd_d = 1'b1;
                                    end
                                end
                                sfsp_pkg::OP_STATUS_WRITE_INSTR: begin
                                    if (byte_q == sfsp_pkg::BYTES_STATUS_WRITE_INSTR &&
                                        wel_q && !hw_locked) begin
                                        lock_d = wdata_q[sfsp_pkg::ST_LOCK];
                                        bp_d = wdata_q[
                                            sfsp_pkg::ST_BP_LO +: 3];
                                        busy_d = 1'b1;
                                        start_d = 1'b1;
                                        cyc_d.kind = sfsp_pkg::CYC_STATUS_WRITE_INSTR;
                                        cyc_d.addr = 24'h0;
                                        cyc_d.status = wdata_q;
                                    end
                                end
                                sfsp_pkg::OP_PP, sfsp_pkg::OP_PP_FAST: begin
                                    if (byte_q >= sfsp_pkg::BYTES_PP_MIN &&
                                        wel_q && !prot_hit(bp_q, addr_q)) begin
                                        busy_d = 1'b1;
                                        start_d = 1'b1;
                                        cyc_d.kind = sfsp_pkg::CYC_PP;
                                        cyc_d.addr = addr_q;
                                        cyc_d.status = status;
                                    end
                                end
                                sfsp_pkg::OP_SE, sfsp_pkg::OP_BE32,
                                sfsp_pkg::OP_BE64: begin
                                    cyc_d.kind = (op_q == sfsp_pkg::OP_SE) ?
                                        sfsp_pkg::CYC_SE :
                                        (op_q == sfsp_pkg::OP_BE32) ?
                                        sfsp_pkg::CYC_BE32 :
                                        sfsp_pkg::CYC_BE64;
                                    cyc_d.addr = addr_q & (
                                        (op_q == sfsp_pkg::OP_SE) ?
                                        sfsp_pkg::SECTOR_MASK :
                                        (op_q == sfsp_pkg::OP_BE32) ?
                                        sfsp_pkg::HALF_MASK :
                                        sfsp_pkg::BLOCK_MASK);
                                    cyc_d.status = status;
                                    if (byte_q == sfsp_pkg::BYTES_ADDR &&
                                        wel_q &&
                                        !prot_hit(bp_q, cyc_d.addr)) begin
                                        busy_d = 1'b1;
                                        start_d = 1'b1;
                                    end
                                end
                                sfsp_pkg::OP_CE_A, sfsp_pkg::OP_CE_B: begin
                                    if (byte_q == sfsp_pkg::BYTES_ONE &&
                                        wel_q && bp_q == 3'h0) begin
                                        busy_d = 1'b1;
                                        start_d = 1'b1;
                                        cyc_d.kind = sfsp_pkg::CYC_CE;
                                        cyc_d.addr = 24'h0;
                                        cyc_d.status = status;
                                    end
                                end
                                default: ;
                            endcase
                        end
                    end
                end
            end
            default: fr_d = sfsp_pkg::FR_WAIT_HIGH;
        endcase

        if (por) begin
            fr_d = sfsp_pkg::FR_WAIT_HIGH;
            so_oe_d = 1'b0;
            l0_oe_d = 1'b0;
            wel_d = 1'b0;
            busy_d = 1'b0;
            dpd_d = 1'b0;
            start_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            fr_q <= sfsp_pkg::FR_WAIT_HIGH;
            sclk_p_q <= 1'b0;
            cs_p_q <= 1'b0;
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            shift_q <= 8'h00;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            wdata_q <= 8'h00;
            lock_q <= sfsp_pkg::RST_LOCK;
            bp_q <= sfsp_pkg::RST_BP;
            wel_q <= 1'b0;
            busy_q <= 1'b0;
            dpd_q <= 1'b0;
            start_q <= 1'b0;
            cyc_q <= '0;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            l0_q <= 1'b0;
            l0_oe_q <= 1'b0;
            pair_q <= 2'h0;
            raddr_q <= 24'h000000;
        end else begin
            fr_q <= fr_d;
            sclk_p_q <= sclk_p_d;
            cs_p_q <= cs_p_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            shift_q <= shift_d;
            op_q <= op_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            lock_q <= lock_d;
            bp_q <= bp_d;
            wel_q <= wel_d;
            busy_q <= busy_d;
            dpd_q <= dpd_d;
            start_q <= start_d;
            cyc_q <= cyc_d;
            so_q <= so_d;
            so_oe_q <= so_oe_d;
            l0_q <= l0_d;
            l0_oe_q <= l0_oe_d;
            pair_q <= pair_d;
            raddr_q <= raddr_d;
        end
    end

    assign o_lane1 = so_q;
    assign o_lane1_oe = so_oe_q;
    assign o_lane0 = l0_q;
    assign o_lane0_oe = l0_oe_q;
    // next byte address is shown early so the array data settles
    assign o_read_addr = so_oe_q ? raddr_q : addr_q;
    assign o_cycle_start = start_q;
    assign o_cycle = cyc_q;
    assign o_status = status;
    // active while selected, standby when deselected and not busy
    assign o_active = (fr_q == sfsp_pkg::FR_SHIFT);
    assign o_standby = (fr_q != sfsp_pkg::FR_SHIFT) & ~busy_q;
    assign o_deep_pd = dpd_q;
endmodule // sfsp_status_protect

// >>> sfsp_status_protect_properties.sv
`timescale 1ns/10ps
module sfsp_status_protect_properties (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic i_por_hold,
    input wire logic i_cycle_done,
    input wire logic o_cycle_start,
    input wire sfsp_pkg::sfsp_cyc_s o_cycle,
    input wire logic [7:0] o_status,
    input wire logic o_active,
    input wire logic o_standby,
    input wire logic o_deep_pd,
    input wire logic o_lane1_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    busy_on_start_a: assert property (
        o_cycle_start |=> o_status[0]) else $error("busy not set");
    start_needs_wel_a: assert property (
        o_cycle_start |-> $past(o_status[1]) && !$past(o_status[0]))
        else $error("start without latch or while busy");
    done_clears_a: assert property (
        i_cycle_done && o_status[0] |=> !o_status[0] && !o_status[1])
        else $error("done did not clear busy and latch");
    reserved_zero_a: assert property (
        o_status[6:5] == 2'b00) else $error("reserved bits set");
    protect_all_a: assert property (
        o_cycle_start && o_status[4:2] == 3'h7
        |-> o_cycle.kind == sfsp_pkg::CYC_STATUS_WRITE_INSTR) else $error("write in full lock");
    code_by_status_write_instr_a: assert property (
        $changed(o_status[4:2]) |-> o_cycle.kind == sfsp_pkg::CYC_STATUS_WRITE_INSTR
        && (o_cycle_start || $past(o_cycle_start))) else $error("code changed");
    standby_busy_a: assert property (
        o_status[0] || o_active |-> !o_standby) else $error("standby early");
    idle_deselect_a: assert property (
        i_cs_n [*8] |-> !o_active && !o_lane1_oe) else $error("active idle");
    por_quiet_a: assert property (
        i_por_hold [*6] |-> !o_active && !o_status[1] && !o_lane1_oe)
        else $error("response under power-on hold");
    deep_silent_a: assert property (
        o_deep_pd |-> !o_cycle_start && !o_lane1_oe) else $error("deep pd act");
endmodule // sfsp_status_protect_properties

bind sfsp_status_protect sfsp_status_protect_properties i_props (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cs_n(i_cs_n),
    .i_por_hold(i_por_hold), .i_cycle_done(i_cycle_done),
    .o_cycle_start(o_cycle_start), .o_cycle(o_cycle), .o_status(o_status),
    .o_active(o_active), .o_standby(o_standby), .o_deep_pd(o_deep_pd),
    .o_lane1_oe(o_lane1_oe));

// >>> sfsp_host_model.sv
`timescale 1ns/10ps
module sfsp_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso,
    input wire logic i_io0
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // mode 0, bit set up before rise
    task automatic frame(input logic [39:0] d, input int nb,
            output logic [7:0] rx, output logic [7:0] rx0);
        #400;
        o_cs_n = 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            o_mosi = (i < 40) ? d[39 - i] : 1'b0;
            #100;
            o_sclk = 1'b1;
            #100;
            // late sample: answer trails the fall by a few system clocks
            rx = {rx[6:0], i_miso};
            rx0 = {rx0[6:0], i_io0};
            o_sclk = 1'b0;
        end
        #100;
        o_cs_n = 1'b1;
        // released line must not hold its last value
        o_mosi = ~o_mosi;
    endtask
endmodule // sfsp_host_model

// >>> tb.sv
`timescale 1ns/10ps
module tb;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic i_wp_n = 1'b1;
    logic i_por_hold = 1'b0;
    logic i_cycle_done = 1'b0;
    logic sclk, cs_n, mosi, lane1, lane1_oe, cyc_start, deep_pd;
    logic [7:0] status, rx, rx0, rdat;
    logic lane0, lane0_oe;
    logic [23:0] raddr;
    assign rdat = raddr[7:0] ^ 8'h5A;
    sfsp_pkg::sfsp_cyc_s cyc;
    int fail_count = 0;
    int compares = 0;
    int write_enable_latch = 0, busy = 0, lock = 0, bp = 0;
    logic [23:0] lim [8] = '{24'h000000, 24'h0FDFFF, 24'h0FBFFF,
        24'h0F7FFF, 24'h0EFFFF, 24'h0DFFFF, 24'h0BFFFF, 24'h0FFFFF};

    always #12.5 i_clk_sys = ~i_clk_sys;

    sfsp_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(lane1_oe ? lane1 : 1'b1),
        .i_io0(lane0_oe ? lane0 : 1'b1));
    sfsp_status_protect i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_lane0(mosi), .o_lane0(lane0),
        .o_lane0_oe(lane0_oe), .i_lane1(1'b0), .o_lane1(lane1),
        .o_lane1_oe(lane1_oe), .i_wp_n(i_wp_n), .i_por_hold(i_por_hold),
        .i_read_data(rdat), .o_read_addr(raddr), .o_cycle_start(cyc_start),
        .o_cycle(cyc), .i_cycle_done(i_cycle_done), .o_status(status),
        .o_active(), .o_standby(), .o_deep_pd(deep_pd));

    function automatic logic [7:0] st();
        return {lock[0], 2'b00, bp[2:0], write_enable_latch[0], busy[0]};
    endfunction
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic fr(input logic [31:0] d, input int nb);
        i_host.frame({d, 8'h00}, nb, rx, rx0);
    endtask
    task automatic dual(input logic [23:0] a);
        logic [7:0] b0, b1;
        b0 = a[7:0] ^ 8'h5A;
        b1 = (a[7:0] + 8'h01) ^ 8'h5A;
        fr({8'h3B, a}, 6);
        chk(rx, {b0[7], b0[5], b0[3], b0[1],
            b1[7], b1[5], b1[3], b1[1]});
        chk(rx0, {b0[6], b0[4], b0[2], b0[0],
            b1[6], b1[4], b1[2], b1[0]});
    endtask
    task automatic rdst();
        fr(32'h05000000, 2);
        chk(rx, st());
    endtask
    task automatic wen();
        fr(32'h06000000, 1);
        write_enable_latch = 1;
    endtask
    task automatic go(input int ok, input logic [2:0] k, input logic [23:0] a);
        int seen;
        seen = 0;
        for (int i = 0; i < 40 && seen == 0; i++) begin
            @(negedge i_clk_sys);
            seen = (cyc_start === 1'b1);
        end
        chk(seen, ok);
        if (seen != ok)
            summarize();
        if (seen) begin
            chk(cyc.kind, k);
            if (k != sfsp_pkg::CYC_STATUS_WRITE_INSTR)
                chk(cyc.addr, a);
            @(negedge i_clk_sys);
            chk(status[0], 1'b1);
            i_cycle_done = 1'b1;
            @(negedge i_clk_sys);
            i_cycle_done = 1'b0;
            write_enable_latch = 0;
        end
        rdst();
    endtask
    task automatic status_write_instr(input logic [7:0] v);
        int ok;
        fr({8'h01, v, 16'h0000}, 2);
        ok = write_enable_latch && !(lock && !i_wp_n);
        if (ok) begin
            lock = v[7];
            bp = v[4:2];
        end
        go(ok, sfsp_pkg::CYC_STATUS_WRITE_INSTR, 24'h000000);
    endtask
    task automatic erase(input logic [23:0] a);
        logic [23:0] b;
        b = a & 24'hFFF000;
        fr({8'h20, a}, 4);
        go(write_enable_latch && !(bp != 0 && b <= lim[bp]), sfsp_pkg::CYC_SE, b);
    endtask

    initial begin
        void'($urandom(99900));
        @(negedge i_clk_sys) i_host.o_cs_n = 1'b0;
        repeat (19) @(negedge i_clk_sys);
        i_reset = 1'b0;
        repeat (10) @(negedge i_clk_sys);
        fr(32'h06000000, 1);
        rdst();
        erase(24'h000000);
        for (int c = 0; c < 8; c++) begin
            wen();
            status_write_instr({3'b000, c[2:0], 2'b00});
            for (int j = 0; j < 3; j++) begin
                wen();
                erase(j == 0 ? lim[c] : j == 1 ? (lim[c] + 24'h000001)
                    & 24'h0FFFFF : $urandom & 24'h0FFFFF);
            end
        end
        wen();
        status_write_instr(8'h80);
        @(negedge i_clk_sys) i_wp_n = 1'b0;
        wen();
        status_write_instr(8'h1C);
        @(negedge i_clk_sys) i_wp_n = 1'b1;
        wen();
        status_write_instr(8'h00);
        wen();
        @(negedge i_clk_sys) i_por_hold = 1'b1;
        fr(32'h06000000, 1);
        @(negedge i_clk_sys) i_por_hold = 1'b0;
        write_enable_latch = 0;
        rdst();
        dual($urandom & 24'h0FFFFF);
        fr(32'hB9000000, 1);
        repeat (8) @(negedge i_clk_sys);
        chk(deep_pd, 1'b1);
        fr(32'h06000000, 1);
        fr(32'hAB000000, 1);
        repeat (8) @(negedge i_clk_sys);
        chk(deep_pd, 1'b0);
        rdst();
        summarize();
    end
    initial begin
        #2000000;
        fail_count++;
        summarize();
    end
endmodule // tb
